// >>> hdl/bpc_pkg.sv
package bpc_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] BPC_OFF_FIRST_PORT  = 8'h00; // holds pullup_enable_n at bit 7
  localparam logic [7:0] BPC_OFF_SECOND_DATA = 8'h04;
  localparam logic [7:0] BPC_OFF_SECOND_DIR  = 8'h08;
  localparam logic [7:0] BPC_OFF_THIRD_DATA  = 8'h0C;
  localparam logic [7:0] BPC_OFF_THIRD_DIR   = 8'h10;
  localparam logic [7:0] BPC_OFF_IRQ_REQ     = 8'h14; // periph_irq_request_reg
  localparam logic [7:0] BPC_OFF_IRQ_MASK    = 8'h18;
  localparam logic [7:0] BPC_OFF_BANK_SEL    = 8'h1C; // bank_select_reg
  localparam logic [7:0] BPC_OFF_MODE        = 8'h20; // operating mode and sleep

  // field positions
  localparam int BPC_PULLUP_N_BIT  = 7;
  localparam int BPC_CHANGE_IRQ_BIT = 7;
  localparam int BPC_SLEEP_BIT      = 2;

  // reset values
  localparam logic [7:0] BPC_RST_DIR      = 8'hFF; // all inputs
  localparam logic [7:0] BPC_RST_LATCH    = 8'h00;
  localparam logic       BPC_RST_PULLUP_N = 1'b0;  // pull-ups on
  localparam logic       BPC_RST_MASK     = 1'b0;  // change irq masked
  localparam logic [7:0] BPC_RST_BANK     = 8'h00;
  localparam logic [1:0] BPC_RST_MODE     = 2'b00;
  localparam logic [3:0] BPC_BANK_THIRD   = 4'h1;

  // operating configurations
  typedef enum logic [1:0] {
    BPC_MODE_MICROPROC = 2'b00,
    BPC_MODE_EXT_MCU   = 2'b01,
    BPC_MODE_MCU       = 2'b10,
    BPC_MODE_SAFE_MCU  = 2'b11
  } bpc_mode_t;

  // per-port pin carrier
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bpc_pins_t;

endpackage

// >>> hdl/bpc_ports.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - second port: 8 pins, direction bit 1 is input, 0 is output
// - second port read returns pins; write only loads output latch
// - weak pull-ups on all second port pins, on when bit 7 is clear
// - pull-up forced off on any pin set as output
// - every reset leaves the second port pull-ups enabled
// - change compare uses input pins only against latch bits
// - mismatches ORed into change flag at bit 7 of irq request
// - change interrupt wakes the device from sleep
// - flag keeps being set while any mismatch persists
// - third port: 8 pins, direction bit 1 input, 0 output
// - third port read returns pins; write only loads output latch
// - as system bus the third port carries the low address/data byte
// - bus in microprocessor and extended modes, i/o otherwise
// - low four bank select bits choose the visible peripheral bank
module bpc_ports
  import bpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  second_port_in,
  output logic [7:0]       second_port_out,
  output logic [7:0]       second_port_oe,
  output logic [7:0]       second_port_pullup,
  input  wire logic [7:0]  third_port_in,
  output logic [7:0]       third_port_out,
  output logic [7:0]       third_port_oe,
  input  wire logic [7:0]  bus_addr_data_low,
  input  wire logic        bus_drive,
  output logic             sleep_active,
  output logic             wake_pulse,
  output logic             irq
);

  // register state
  logic [7:0] second_latch_reg, second_dir_reg;
  logic [7:0] third_latch_reg, third_dir_reg;
  logic       pullup_enable_n_reg;
  logic       change_irq_flag_reg;
  logic       mask_reg;
  logic [7:0] bank_select_reg;
  bpc_mode_t  mode_reg;
  logic       sleep_reg;

  // three-stage pin synchronisers; stage one feeds stage two only
  logic [7:0] sp_s1, sp_s2, sp_s3, sp_stable;
  logic [7:0] tp_s1, tp_s2, tp_s3, tp_stable;

  logic       wr_en, rd_en, sel_bus;
  logic [7:0] mismatch;
  logic       change_any;
  bpc_pins_t  second_pins, third_pins;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  assign sel_bus = (mode_reg == BPC_MODE_MICROPROC) || (mode_reg == BPC_MODE_EXT_MCU);

  // synchronise pins: a change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_s1     <= 8'h00;
      sp_s2     <= 8'h00;
      sp_s3     <= 8'h00;
      sp_stable <= 8'h00;
      tp_s1     <= 8'h00;
      tp_s2     <= 8'h00;
      tp_s3     <= 8'h00;
      tp_stable <= 8'h00;
    end else if (clk_en) begin
      sp_s1 <= second_port_in;
      sp_s2 <= sp_s1;
      sp_s3 <= sp_s2;
      tp_s1 <= third_port_in;
      tp_s2 <= tp_s1;
      tp_s3 <= tp_s2;
      for (int i = 0; i < 8; i++) begin
        if (sp_s2[i] == sp_s3[i]) sp_stable[i] <= sp_s3[i];
        if (tp_s2[i] == tp_s3[i]) tp_stable[i] <= tp_s3[i];
      end
    end
  end

  // per-pin change compare
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cmp
      assign mismatch[g] = second_dir_reg[g] && (sp_stable[g] != second_latch_reg[g]);
    end
  endgenerate
  assign change_any = |mismatch;

  // software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_latch_reg    <= BPC_RST_LATCH;
      second_dir_reg      <= BPC_RST_DIR;
      third_latch_reg     <= BPC_RST_LATCH;
      third_dir_reg       <= BPC_RST_DIR;
      pullup_enable_n_reg <= BPC_RST_PULLUP_N;
      mask_reg            <= BPC_RST_MASK;
      bank_select_reg     <= BPC_RST_BANK;
      mode_reg            <= bpc_mode_t'(BPC_RST_MODE);
    end else if (clk_en && wr_en) begin
      case (paddr)
        BPC_OFF_FIRST_PORT:  pullup_enable_n_reg <= pwdata[BPC_PULLUP_N_BIT];
        BPC_OFF_SECOND_DATA: second_latch_reg <= pwdata[7:0];
        BPC_OFF_SECOND_DIR:  second_dir_reg   <= pwdata[7:0];
        // third port only visible in bank 1
        BPC_OFF_THIRD_DATA: begin
          if (bank_select_reg[3:0] == BPC_BANK_THIRD) third_latch_reg <= pwdata[7:0];
        end
        BPC_OFF_THIRD_DIR: begin
          if (bank_select_reg[3:0] == BPC_BANK_THIRD) third_dir_reg <= pwdata[7:0];
        end
        BPC_OFF_IRQ_MASK:    mask_reg        <= pwdata[BPC_CHANGE_IRQ_BIT];
        BPC_OFF_BANK_SEL:    bank_select_reg <= pwdata[7:0];
        BPC_OFF_MODE:        mode_reg        <= bpc_mode_t'(pwdata[1:0]);
        default: ;
      endcase
    end
  end

  // change flag: set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (change_any) begin
        change_irq_flag_reg <= 1'b1;
      end else if (wr_en && paddr == BPC_OFF_IRQ_REQ && pwdata[BPC_CHANGE_IRQ_BIT]) begin
        change_irq_flag_reg <= 1'b0;
      end
    end
  end

  // sleep request and wake; wake only when the change is unmasked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg  <= 1'b0;
      wake_pulse <= 1'b0;
    end else if (clk_en) begin
      wake_pulse <= 1'b0;
      if (sleep_reg && change_irq_flag_reg && mask_reg) begin
        sleep_reg  <= 1'b0;
        wake_pulse <= 1'b1;
      end else if (wr_en && paddr == BPC_OFF_MODE) begin
        sleep_reg <= pwdata[BPC_SLEEP_BIT];
      end
    end
  end

  // pin drive, combinational before the output flops
  always_comb begin
    second_pins.oe  = ~second_dir_reg;
    second_pins.out = second_latch_reg;
    // bus byte overrides in bus modes
    if (sel_bus) begin
      third_pins.oe  = {8{bus_drive}};
      third_pins.out = bus_addr_data_low;
    end else begin
      third_pins.oe  = ~third_dir_reg;
      third_pins.out = third_latch_reg;
    end
  end

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_port_out    <= 8'h00;
      second_port_oe     <= 8'h00;
      second_port_pullup <= 8'h00;
      third_port_out     <= 8'h00;
      third_port_oe      <= 8'h00;
    end else if (clk_en) begin
      second_port_out <= second_pins.out;
      second_port_oe  <= second_pins.oe;
      second_port_pullup <= {8{~pullup_enable_n_reg}} & second_dir_reg;
      third_port_out  <= third_pins.out;
      third_port_oe   <= third_pins.oe;
    end
  end

  // apb read path, zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          BPC_OFF_FIRST_PORT:  prdata <= {24'h000000, pullup_enable_n_reg, 7'h00};
          BPC_OFF_SECOND_DATA: prdata <= {24'h000000, sp_stable};
          BPC_OFF_SECOND_DIR:  prdata <= {24'h000000, second_dir_reg};
          BPC_OFF_THIRD_DATA:
            prdata <= (bank_select_reg[3:0] == BPC_BANK_THIRD) ? {24'h000000, tp_stable} : 32'h0000_0000;
          BPC_OFF_THIRD_DIR:
            prdata <= (bank_select_reg[3:0] == BPC_BANK_THIRD) ? {24'h000000, third_dir_reg} : 32'h0000_0000;
          BPC_OFF_IRQ_REQ:     prdata <= {24'h000000, change_irq_flag_reg, 7'h00};
          BPC_OFF_IRQ_MASK:    prdata <= {24'h000000, mask_reg, 7'h00};
          BPC_OFF_BANK_SEL:    prdata <= {24'h000000, bank_select_reg};
          BPC_OFF_MODE:        prdata <= {29'h0000_0000, sleep_reg, mode_reg};
          default:             pslverr <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // level interrupt from the registered flag and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= change_irq_flag_reg && mask_reg;
    end
  end
  assign sleep_active = sleep_reg;

  out_excluded_a: assert property (@(posedge pclk) disable iff (!presetn)
    (second_dir_reg == 8'h00) |-> !change_any) else $error("output pin compared");

  // a mismatch sets the flag next cycle
  flag_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && change_any) |=> change_irq_flag_reg) else $error("flag not set");

  clear_blocked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && change_any && wr_en && paddr == BPC_OFF_IRQ_REQ) |=> change_irq_flag_reg)
    else $error("flag cleared during mismatch");

  pullup_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> ((second_port_pullup & second_port_oe) == 8'h00)) else $error("pull-up on output");

  // pull-ups follow control bit on inputs
  pullup_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !pullup_enable_n_reg) |=> (second_port_pullup == $past(second_dir_reg)))
    else $error("pull-up not enabled");

  latch_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (second_port_out == $past(second_latch_reg))) else $error("latch not driven");

  // sleeping device wakes on unmasked change
  wake_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sleep_reg && change_irq_flag_reg && mask_reg) |=> (wake_pulse && !sleep_reg))
    else $error("no wake on change");

  // general i/o mode uses third direction
  third_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !sel_bus) |=> (third_port_oe == ~$past(third_dir_reg))) else $error("third oe wrong");

  reset_pullup_a: assert property (@(posedge pclk)
    $rose(presetn) |-> !pullup_enable_n_reg) else $error("pull-ups off after reset");

  bus_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sel_bus) |=> (third_port_out == $past(bus_addr_data_low)))
    else $error("bus byte not driven");

  bus_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sel_bus) |=> (third_port_oe == {8{$past(bus_drive)}}))
    else $error("bus enable wrong");

  gpio_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !sel_bus) |=> (third_port_out == $past(third_latch_reg)))
    else $error("third latch not driven");

  second_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (second_port_oe == ~$past(second_dir_reg)))
    else $error("second oe wrong");

  latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && paddr == BPC_OFF_SECOND_DATA) |=> (second_latch_reg == $past(pwdata[7:0])))
    else $error("second latch not written");

  second_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == BPC_OFF_SECOND_DATA)
    |=> (prdata == {24'h000000, $past(sp_stable)}))
    else $error("second read not pins");

  third_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == BPC_OFF_THIRD_DATA
     && bank_select_reg[3:0] == BPC_BANK_THIRD) |=> (prdata == {24'h000000, $past(tp_stable)}))
    else $error("third read not pins");

  third_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && paddr == BPC_OFF_THIRD_DATA && bank_select_reg[3:0] == BPC_BANK_THIRD)
    |=> (third_latch_reg == $past(pwdata[7:0])))
    else $error("third latch not written");

  third_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && paddr == BPC_OFF_THIRD_DIR && bank_select_reg[3:0] == BPC_BANK_THIRD)
    |=> (third_dir_reg == $past(pwdata[7:0])))
    else $error("third direction not written");

  // other banks leave third port alone
  bank_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && (paddr == BPC_OFF_THIRD_DATA || paddr == BPC_OFF_THIRD_DIR)
     && bank_select_reg[3:0] != BPC_BANK_THIRD) |=> ($stable(third_latch_reg) && $stable(third_dir_reg)))
    else $error("third port written in wrong bank");

  bank_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pwrite && paddr == BPC_OFF_THIRD_DATA
     && bank_select_reg[3:0] != BPC_BANK_THIRD) |=> (prdata == 32'h0000_0000))
    else $error("third port read in wrong bank");

  // irq level follows flag and mask
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (irq == $past(change_irq_flag_reg && mask_reg)))
    else $error("irq level wrong");

  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && change_irq_flag_reg && !(wr_en && paddr == BPC_OFF_IRQ_REQ && pwdata[BPC_CHANGE_IRQ_BIT]))
    |=> change_irq_flag_reg)
    else $error("flag dropped");

  pullup_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pullup_enable_n_reg) |=> (second_port_pullup == 8'h00))
    else $error("pull-up on while disabled");

  wake_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_pulse |-> !sleep_reg)
    else $error("still asleep after wake");

  no_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !(sleep_reg && change_irq_flag_reg && mask_reg)) |=> !wake_pulse)
    else $error("spurious wake");

  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable) |=> pready)
    else $error("no ready in access");

  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !(wr_en && paddr == BPC_OFF_SECOND_DATA)) |=> $stable(second_latch_reg))
    else $error("latch changed unwritten");

endmodule

`default_nettype wire

// >>> verification/bidir_ports_change_irq_test.sv
`timescale 1ns/1ps
`default_nettype none
module bidir_ports_change_irq_test
  import bpc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        sleep_active, wake_pulse, irq, bus_drive, got;
  logic [7:0]  paddr, sp_pin, sp_out, sp_oe, sp_pu, key_down, tp_pin, tp_out, tp_oe, bus_byte;
  logic [31:0] pwdata, prdata, rdat;
  int          num_errors, tests_run;
  // row: address, write value, read mask, expected read
  logic [31:0] rows [6] = '{{BPC_OFF_FIRST_PORT, 24'h008000}, {BPC_OFF_SECOND_DIR, 24'h0FFF0F},
    {BPC_OFF_BANK_SEL, 24'h010F01}, {BPC_OFF_THIRD_DATA, 24'h3CFF96},
    {BPC_OFF_IRQ_MASK, 24'h808080}, {BPC_OFF_MODE, 24'h020702}};

  bpc_ports bpc_ports_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .second_port_in(sp_pin), .second_port_out(sp_out), .second_port_oe(sp_oe), .second_port_pullup(sp_pu),
    .third_port_in(tp_pin), .third_port_out(tp_out), .third_port_oe(tp_oe), .bus_addr_data_low(bus_byte),
    .bus_drive(bus_drive), .sleep_active(sleep_active), .wake_pulse(wake_pulse), .irq(irq));

  bpc_pin_model bpc_pin_model_inst (.pclk(pclk), .sp_out(sp_out), .sp_oe(sp_oe), .sp_pu(sp_pu),
    .key_down(key_down), .tp_out(tp_out), .tp_oe(tp_oe), .tp_ext(8'h96), .sp_pin(sp_pin), .tp_pin(tp_pin));

  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic final_report();
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; waits for pready, a hang is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, rdat & m);
  endtask

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, bus_drive, bus_byte, key_down} = '0;
    num_errors = 0;
    tests_run = 0;
    idle(6);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i][31:24], {24'h0, rows[i][23:16]});
      rdchk(rows[i][31:24], {24'h0, rows[i][15:8]}, {24'h0, rows[i][7:0]});
    end
    chk("pullup", 8'h0F, sp_pu);
    chk("sp_oe", 8'hF0, sp_oe);
    // low nibble inputs read high while the latch holds 5
    apb(1'b1, BPC_OFF_SECOND_DATA, 32'hA5);
    idle(8);
    chk("sp_out", 8'hA5, sp_out);
    rdchk(BPC_OFF_SECOND_DATA, 32'hFF, 32'hAF);
    rdchk(BPC_OFF_IRQ_REQ, 32'h80, 32'h80);
    chk("irq", 1'b1, irq);
    apb(1'b1, BPC_OFF_IRQ_REQ, 32'h80);
    idle(2);
    rdchk(BPC_OFF_IRQ_REQ, 32'h80, 32'h80);
    apb(1'b1, BPC_OFF_SECOND_DATA, 32'hAF);
    idle(8);
    apb(1'b1, BPC_OFF_IRQ_REQ, 32'h80);
    idle(2);
    rdchk(BPC_OFF_IRQ_REQ, 32'h80, 32'h00);
    chk("irq", 1'b0, irq);
    // sleep, then a key press must wake
    apb(1'b1, BPC_OFF_MODE, 32'h06);
    key_down <= 8'h01;
    got = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      got = got | wake_pulse;
    end
    chk("wake", 1'b1, got);
    chk("sleep", 1'b0, sleep_active);
    key_down <= 8'h00;
    // third port across all four configurations
    apb(1'b1, BPC_OFF_THIRD_DIR, 32'h00);
    bus_drive <= 1'b1;
    bus_byte <= 8'hC3;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, BPC_OFF_MODE, 32'(m));
      idle(2);
      chk("tp_out", (m < 2) ? 8'hC3 : 8'h3C, tp_out);
      chk("tp_oe", 8'hFF, tp_oe);
    end
    rdchk(BPC_OFF_THIRD_DATA, 32'hFF, 32'h3C);
    apb(1'b1, BPC_OFF_THIRD_DIR, 32'hFF);
    idle(6);
    rdchk(BPC_OFF_THIRD_DATA, 32'hFF, 32'h96);
    chk("tp_oe", 8'h00, tp_oe);
    chk("tp_out", 8'h3C, tp_out);
    apb(1'b1, BPC_OFF_BANK_SEL, 32'h0);
    rdchk(BPC_OFF_THIRD_DATA, 32'hFF, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk("slverr", 1'b1, rerr);
    // mid-run reset restores pull-ups and inputs
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(2);
    chk("pullup", 8'hFF, sp_pu);
    rdchk(BPC_OFF_FIRST_PORT, 32'h80, 32'h0);
    rdchk(BPC_OFF_SECOND_DIR, 32'hFF, 32'hFF);
    final_report();
  end
endmodule
`default_nettype wire

// >>> verification/bpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// pad side of both ports: key switches, weak pull-ups, released lines
module bpc_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] sp_out,
  input  wire logic [7:0] sp_oe,
  input  wire logic [7:0] sp_pu,
  input  wire logic [7:0] key_down,
  input  wire logic [7:0] tp_out,
  input  wire logic [7:0] tp_oe,
  input  wire logic [7:0] tp_ext,
  output logic [7:0]      sp_pin,
  output logic [7:0]      tp_pin
);
  logic [7:0] flt_reg = 8'h5A;
  // floating lines wander, so a missing pull-up cannot pass by luck
  always @(posedge pclk) begin
    flt_reg <= ~flt_reg;
  end
  // keys only on a port kept for change sensing
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (sp_oe[i])
        sp_pin[i] = sp_out[i];
      else if (key_down[i])
        sp_pin[i] = 1'b0; // key shorts pin to ground
      else
        sp_pin[i] = sp_pu[i] ? 1'b1 : flt_reg[i];
    end
  end
  // third port: own driver wins, else the outside source
  assign tp_pin = (tp_oe & tp_out) | (~tp_oe & tp_ext);
endmodule
`default_nettype wire
